// ==== asdl_dma_model.sv ====
// Purpose: dma engine and fifo stand-in for the link control
// Assumes: same clock as the control block
// Notes: stall freezes fifo traffic so the hang timer can run out
module asdl_dma_model import asdl_pkg::*; (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire asdl_dma_ctrl_t ctrl, // dma ctrl
	input wire logic run, // traffic on
	input wire logic stall, // traffic frozen
	output asdl_dma_stat_t stat, // status
	output logic empty, // tx fifo empty
	output logic tx_prog, // tx moved
	output logic rx_prog, // rx moved
	output logic act // work pending
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] words_reg;
	logic slow_reg;
	always_ff @(posedge clk) begin
		slow_reg <= rstn && !slow_reg;
		if (!rstn || ctrl.tx_dma_reset) begin
			words_reg <= 32'h0;
		end else if (tx_prog) begin
			words_reg <= words_reg + 32'h1;
		end
	end
	// slow traffic: each direction moves a word every other cycle
	assign tx_prog = run && !stall && slow_reg && !ctrl.tx_dma_reset;
	assign rx_prog = run && !stall && !slow_reg && !ctrl.rx_dma_reset;
	assign empty = !run || stall;
	assign act = run;
	assign stat = {32'h00001000, 32'h00001010, 32'h00002000, 32'h0000A5A5, words_reg};
endmodule : asdl_dma_model

// ==== asdl_link_ctrl.sv ====
// Purpose: register file, hang timer and control fan-out for the serial audio dma link
// Assumes: one 50 MHz clock, apb slave with zero wait states, sync active-low reset
// Notes: dma engine status arrives from the same clock domain
//
// Chosen here: the APB interface to the registers.
module asdl_link_ctrl import asdl_pkg::*; (
	input wire logic clk, // 50 MHz system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire asdl_dma_stat_t dma_stat, // engine addresses and status words
	input wire logic tx_fifo_empty, // tx fifo holds no data
	input wire logic tx_fifo_progress, // tx fifo moved a word this cycle
	input wire logic rx_fifo_progress, // rx fifo moved a word this cycle
	input wire logic tx_active, // tx direction has work pending
	input wire logic rx_active, // rx direction has work pending
	output asdl_dma_ctrl_t dma_ctrl, // dma engine configuration
	output asdl_path_ctrl_t path_ctrl, // companding, stop and power controls
	output logic serial_clk_en, // bit clock and word select may run
	output logic tx_hang_pulse, // tx data timeout event, one cycle
	output logic rx_hang_pulse // rx data timeout event, one cycle
);
	logic [31:0] link_conf_reg;
	logic [31:0] hang_conf_reg;
	logic [31:0] compand_conf_reg;
	logic [31:0] power_conf_reg;
	logic [31:0] secondary_conf_reg;
	logic [16:0] tick_cnt_reg;
	logic [7:0] tx_hang_cnt_reg;
	logic [7:0] rx_hang_cnt_reg;
	logic [16:0] tick_limit;
	logic tick;
	logic hang_en;
	logic [7:0] hang_limit;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [31:0] rd_next;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	always_comb begin
		addr_ok = 1'b1;
		rd_next = SLAVE_ERROR_DATA;
		case (paddr)
			TX_CUR_DSCR_OFS: rd_next = dma_stat.tx_cur_dscr;
			TX_NEXT_DSCR_OFS: rd_next = dma_stat.tx_next_dscr;
			TX_NEXT_BUF_OFS: rd_next = dma_stat.tx_next_buf;
			LINK_CONF_OFS: rd_next = link_conf_reg;
			RX_STATUS_OFS: rd_next = dma_stat.rx_status;
			TX_STATUS_OFS: rd_next = dma_stat.tx_status;
			HANG_CONF_OFS: rd_next = hang_conf_reg;
			COMPAND_CONF_OFS: rd_next = compand_conf_reg;
			POWER_CONF_OFS: rd_next = power_conf_reg;
			SECONDARY_CONF_OFS: rd_next = secondary_conf_reg;
			default: addr_ok = 1'b0;
		endcase
	end

	// read data is captured in setup so the access phase completes at once
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			if (rd_en) begin
				prdata <= rd_next;
			end
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			link_conf_reg <= LINK_CONF_RESET;
			hang_conf_reg <= HANG_CONF_RESET;
			compand_conf_reg <= COMPAND_CONF_RESET;
			power_conf_reg <= POWER_CONF_RESET;
			secondary_conf_reg <= SECONDARY_CONF_RESET;
		end else if (wr_en) begin
			case (paddr)
				LINK_CONF_OFS: link_conf_reg <= {20'h00000, pwdata[LC_WIDTH-1:0]};
				HANG_CONF_OFS: hang_conf_reg <= {20'h00000, pwdata[HC_EN:0]};
				COMPAND_CONF_OFS: compand_conf_reg <= {27'h0000000, pwdata[CP_TX_STOP:0]};
				POWER_CONF_OFS: power_conf_reg <= {30'h00000000, pwdata[PW_FORCE_PU:0]};
				SECONDARY_CONF_OFS: secondary_conf_reg <= {24'h000000, pwdata[7:0]};
				default: ;
			endcase
		end
	end

	function automatic asdl_compand_t compand_mode(input logic bypass, input logic sel);
		if (bypass) begin
			compand_mode = ASDL_MODE_BYPASS;
		end else if (sel) begin
			compand_mode = ASDL_MODE_COMPRESS;
		end else begin
			compand_mode = ASDL_MODE_DECOMPRESS;
		end
	endfunction : compand_mode

	// resets are levels: the engine stays held until software writes 0
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dma_ctrl <= '0;
			path_ctrl <= '{ASDL_MODE_BYPASS, ASDL_MODE_BYPASS, 1'b0, 1'b0, 1'b0};
		end else begin
			dma_ctrl.owner_check <= link_conf_reg[LC_OWNER_CHECK];
			dma_ctrl.tx_data_burst <= link_conf_reg[LC_TX_DATA_BURST];
			dma_ctrl.rx_descriptor_burst_en <= link_conf_reg[LC_RX_DSCR_BURST];
			dma_ctrl.tx_descriptor_burst_en <= link_conf_reg[LC_TX_DSCR_BURST];
			dma_ctrl.eof_after_pop <= link_conf_reg[LC_EOF_MODE];
			dma_ctrl.tx_auto_writeback_en <= link_conf_reg[LC_AUTO_WB];
			dma_ctrl.tx_loop_test <= link_conf_reg[LC_TX_LOOP];
			dma_ctrl.rx_loop_test <= link_conf_reg[LC_RX_LOOP];
			dma_ctrl.bus_master_reset <= link_conf_reg[LC_BM_RST];
			dma_ctrl.bus_master_cmd_queue_reset <= link_conf_reg[LC_CMDQ_RST];
			dma_ctrl.tx_dma_reset <= link_conf_reg[LC_TX_RST];
			dma_ctrl.rx_dma_reset <= link_conf_reg[LC_RX_RST];
			path_ctrl.rx_mode <= compand_mode(compand_conf_reg[CP_RX_BYPASS],
				compand_conf_reg[CP_RX_SEL]);
			path_ctrl.tx_mode <= compand_mode(compand_conf_reg[CP_TX_BYPASS],
				compand_conf_reg[CP_TX_SEL]);
			path_ctrl.tx_stop_en <= compand_conf_reg[CP_TX_STOP];
			path_ctrl.fifo_force_power_up <= power_conf_reg[PW_FORCE_PU];
			path_ctrl.fifo_force_power_down <= power_conf_reg[PW_FORCE_PD];
		end
	end

	// clocks stop only once the fifo is empty, so a partial word is never cut
	always_ff @(posedge clk) begin
		if (!rstn) begin
			serial_clk_en <= 1'b1;
		end else begin
			serial_clk_en <= ~(compand_conf_reg[CP_TX_STOP] & tx_fifo_empty);
		end
	end

	assign hang_en = hang_conf_reg[HC_EN];
	assign hang_limit = hang_conf_reg[HC_LIMIT_LSB +: HC_LIMIT_W];
	assign tick_limit = HANG_TICK_BASE >> hang_conf_reg[HC_SHIFT_LSB +: HC_SHIFT_W];
	assign tick = hang_en && (tick_cnt_reg >= tick_limit);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			tick_cnt_reg <= 17'h00000;
		end else if (!hang_en) begin
			tick_cnt_reg <= 17'h00000;
		end else if (tick) begin
			tick_cnt_reg <= 17'h00000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 17'h00001;
		end
	end

	// a hang counter advances per tick while work is pending and nothing moves
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_hang_cnt_reg <= 8'h00;
			rx_hang_cnt_reg <= 8'h00;
			tx_hang_pulse <= 1'b0;
			rx_hang_pulse <= 1'b0;
		end else begin
			tx_hang_pulse <= 1'b0;
			rx_hang_pulse <= 1'b0;
			if (!hang_en || tx_fifo_progress || !tx_active) begin
				tx_hang_cnt_reg <= 8'h00;
			end else if (tick) begin
				if (tx_hang_cnt_reg + 8'h01 == hang_limit) begin
					tx_hang_pulse <= 1'b1;
					tx_hang_cnt_reg <= 8'h00;
				end else begin
					tx_hang_cnt_reg <= tx_hang_cnt_reg + 8'h01;
				end
			end
			if (!hang_en || rx_fifo_progress || !rx_active) begin
				rx_hang_cnt_reg <= 8'h00;
			end else if (tick) begin
				if (rx_hang_cnt_reg + 8'h01 == hang_limit) begin
					rx_hang_pulse <= 1'b1;
					rx_hang_cnt_reg <= 8'h00;
				end else begin
					rx_hang_cnt_reg <= rx_hang_cnt_reg + 8'h01;
				end
			end
		end
	end
endmodule : asdl_link_ctrl

// ==== asdl_link_ctrl_asserts.sv ====
// Purpose: port checks for asdl_link_ctrl
// Assumes: one clock, sync active-low reset
// Notes: controls reach the outputs two edges after a write
module asdl_link_ctrl_asserts import asdl_pkg::*; (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // write
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire asdl_dma_stat_t dma_stat, // status in
	input wire logic tx_fifo_empty, // empty
	input wire logic tx_active, // tx busy
	input wire asdl_dma_ctrl_t dma_ctrl, // dma ctrl
	input wire asdl_path_ctrl_t path_ctrl, // path ctrl
	input wire logic serial_clk_en, // clock run
	input wire logic tx_hang_pulse // tx timeout
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no pready");
	cur_dscr_read_a: assert property (psel && !penable && !pwrite && paddr == TX_CUR_DSCR_OFS
		|=> prdata == $past(dma_stat.tx_cur_dscr)) else $error("bad descriptor read");
	status_read_a: assert property (psel && !penable && !pwrite && paddr == TX_STATUS_OFS
		|=> prdata == $past(dma_stat.tx_status)) else $error("bad status read");
	err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == SLAVE_ERROR_DATA)
		else $error("error read not zero");
	// four edges of history keep the post-reset reload out of the check
	ctrl_hold_a: assert property (($past(rstn, 4) && !(psel && penable && pwrite))[*3]
		|=> $stable(dma_ctrl) && $stable(path_ctrl)) else $error("control moved");
	stop_halts_clk_a: assert property (path_ctrl.tx_stop_en && tx_fifo_empty
		##1 path_ctrl.tx_stop_en |-> !serial_clk_en) else $error("clock not stopped");
	clk_runs_a: assert property (!tx_fifo_empty |=> serial_clk_en)
		else $error("clock stopped");
	idle_no_hang_a: assert property (!tx_active[*2] |=> !tx_hang_pulse)
		else $error("timeout while idle");
	cover property (pslverr);
	cover property (tx_hang_pulse);
	cover property (!serial_clk_en);
endmodule : asdl_link_ctrl_asserts
bind asdl_link_ctrl asdl_link_ctrl_asserts chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .dma_stat, .tx_fifo_empty, .tx_active, .dma_ctrl, .path_ctrl,
	.serial_clk_en, .tx_hang_pulse);

// ==== asdl_link_ctrl_bench.sv ====
// Purpose: self-checking bench for asdl_link_ctrl
// Assumes: 50 MHz clock, apb slave answers within 20 cycles
// Notes: largest tick shift keeps the hang test short
module asdl_link_ctrl_bench import asdl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic run = 1'b0, stall = 1'b0, err, rxs;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, empty, tx_prog, rx_prog, act, serial_clk_en, tx_hang_pulse;
	logic rx_hang_pulse;
	asdl_dma_stat_t stat;
	asdl_dma_ctrl_t dma_ctrl;
	asdl_path_ctrl_t path_ctrl;
	int mismatches = 0, checked = 0, n;
	always #10 clk = ~clk;
	asdl_link_ctrl uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .dma_stat(stat), .tx_fifo_empty(empty), .tx_fifo_progress(tx_prog),
		.rx_fifo_progress(rx_prog), .tx_active(act), .rx_active(act), .dma_ctrl, .path_ctrl,
		.serial_clk_en, .tx_hang_pulse, .rx_hang_pulse);
	asdl_dma_model mem (.clk, .rstn, .ctrl(dma_ctrl), .run, .stall, .stat, .empty, .tx_prog,
		.rx_prog, .act);
	task automatic test_done();
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask : rdchk
	function automatic asdl_compand_t md(input logic byp, input logic sel);
		return byp ? ASDL_MODE_BYPASS : (sel ? ASDL_MODE_COMPRESS : ASDL_MODE_DECOMPRESS);
	endfunction : md
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rdchk(LINK_CONF_OFS, LINK_CONF_RESET);
		rdchk(HANG_CONF_OFS, HANG_CONF_RESET);
		rdchk(COMPAND_CONF_OFS, COMPAND_CONF_RESET);
		rdchk(POWER_CONF_OFS, POWER_CONF_RESET);
		rdchk(SECONDARY_CONF_OFS, SECONDARY_CONF_RESET);
		cmp({31'h0, serial_clk_en}, 32'h1);
		rdchk(TX_CUR_DSCR_OFS, 32'h00001000);
		apb(1'b1, TX_NEXT_DSCR_OFS, 32'hFFFFFFFF);
		rdchk(TX_NEXT_DSCR_OFS, 32'h00001010);
		rdchk(TX_NEXT_BUF_OFS, 32'h00002000);
		rdchk(RX_STATUS_OFS, 32'h0000A5A5);
		apb(1'b1, 8'h64, 32'hFFFFFFFF);
		cmp({31'h0, err}, 32'h1);
		rdchk(8'h64, SLAVE_ERROR_DATA);
		run <= 1'b1;
		for (int i = 0; i < LC_WIDTH; i++) begin
			apb(1'b1, LINK_CONF_OFS, 32'h1 << i);
			repeat (2) @(posedge clk);
			cmp({20'h0, dma_ctrl}, 32'h1 << i);
			rdchk(LINK_CONF_OFS, 32'h1 << i);
			if (i == LC_TX_RST) rdchk(TX_STATUS_OFS, 32'h0);
		end
		for (int v = 0; v < 16; v++) begin
			apb(1'b1, COMPAND_CONF_OFS, 32'(v));
			repeat (2) @(posedge clk);
			cmp({28'h0, path_ctrl.tx_mode, path_ctrl.rx_mode}, {28'h0, md(v[1], v[0]), md(v[3], v[2])});
		end
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, POWER_CONF_OFS, 32'(p));
			repeat (2) @(posedge clk);
			cmp({30'h0, path_ctrl.fifo_force_power_up, path_ctrl.fifo_force_power_down}, 32'(p));
		end
		apb(1'b1, COMPAND_CONF_OFS, 32'h0000001A);
		repeat (3) @(posedge clk);
		cmp({31'h0, serial_clk_en}, 32'h1);
		// stalling empties the tx fifo and starves both directions
		apb(1'b1, HANG_CONF_OFS, 32'h00000F02);
		stall <= 1'b1;
		n = 0;
		rxs = 1'b0;
		do begin
			@(posedge clk);
			n++;
			rxs |= rx_hang_pulse;
		end while (tx_hang_pulse !== 1'b1 && n < 4000);
		cmp({31'h0, serial_clk_en}, 32'h0);
		cmp(32'(n > 687 && n < 2073), 32'h1);
		if (n == 4000) test_done();
		repeat (2) begin
			@(posedge clk);
			rxs |= rx_hang_pulse;
		end
		cmp({31'h0, rxs}, 32'h1);
		apb(1'b1, HANG_CONF_OFS, 32'h00000702);
		repeat (3) @(posedge clk);
		rxs = 1'b0;
		repeat (2100) begin
			@(posedge clk);
			rxs |= tx_hang_pulse | rx_hang_pulse;
		end
		cmp({31'h0, rxs}, 32'h0);
		test_done();
	end
endmodule : asdl_link_ctrl_bench

// ==== asdl_pkg.sv ====
// Purpose: constants and types for the audio serial dma link control block
// Assumes: 32-bit apb register bus, byte addresses as printed
// Notes: field positions not printed are chosen here
package asdl_pkg;
	localparam logic [7:0] TX_CUR_DSCR_OFS = 8'h54;
	localparam logic [7:0] TX_NEXT_DSCR_OFS = 8'h58;
	localparam logic [7:0] TX_NEXT_BUF_OFS = 8'h5C;
	localparam logic [7:0] LINK_CONF_OFS = 8'h60;
	localparam logic [7:0] RX_STATUS_OFS = 8'h6C;
	localparam logic [7:0] TX_STATUS_OFS = 8'h70;
	localparam logic [7:0] HANG_CONF_OFS = 8'h74;
	localparam logic [7:0] COMPAND_CONF_OFS = 8'hA0;
	localparam logic [7:0] POWER_CONF_OFS = 8'hA4;
	localparam logic [7:0] SECONDARY_CONF_OFS = 8'hA8;
	// link configuration bits
	localparam int LC_RX_RST = 0;
	localparam int LC_TX_RST = 1;
	localparam int LC_CMDQ_RST = 2;
	localparam int LC_BM_RST = 3;
	localparam int LC_RX_LOOP = 4;
	localparam int LC_TX_LOOP = 5;
	localparam int LC_AUTO_WB = 6;
	localparam int LC_EOF_MODE = 7;
	localparam int LC_TX_DSCR_BURST = 8;
	localparam int LC_RX_DSCR_BURST = 9;
	localparam int LC_TX_DATA_BURST = 10;
	localparam int LC_OWNER_CHECK = 11;
	localparam int LC_WIDTH = 12;
	// hang configuration fields
	localparam int HC_LIMIT_LSB = 0;
	localparam int HC_LIMIT_W = 8;
	localparam int HC_SHIFT_LSB = 8;
	localparam int HC_SHIFT_W = 3;
	localparam int HC_EN = 11;
	localparam logic [31:0] HANG_CONF_RESET = 32'h00000810;
	// companding and stop bits
	localparam int CP_TX_SEL = 0;
	localparam int CP_TX_BYPASS = 1;
	localparam int CP_RX_SEL = 2;
	localparam int CP_RX_BYPASS = 3;
	localparam int CP_TX_STOP = 4;
	localparam logic [31:0] COMPAND_CONF_RESET = 32'h0000000A;
	// power bits
	localparam int PW_FORCE_PD = 0;
	localparam int PW_FORCE_PU = 1;
	localparam logic [31:0] POWER_CONF_RESET = 32'h00000002;
	localparam logic [31:0] SECONDARY_CONF_RESET = 32'h00000020;
	localparam logic [31:0] LINK_CONF_RESET = 32'h00000780;
	localparam logic [16:0] HANG_TICK_BASE = 17'h157C0; // 88000
	localparam logic [31:0] SLAVE_ERROR_DATA = 32'h00000000;

	typedef enum logic [1:0] {
		ASDL_MODE_BYPASS,
		ASDL_MODE_DECOMPRESS,
		ASDL_MODE_COMPRESS
	} asdl_compand_t;

	typedef struct packed {
		logic owner_check;
		logic tx_data_burst;
		logic rx_descriptor_burst_en;
		logic tx_descriptor_burst_en;
		logic eof_after_pop;
		logic tx_auto_writeback_en;
		logic tx_loop_test;
		logic rx_loop_test;
		logic bus_master_reset;
		logic bus_master_cmd_queue_reset;
		logic tx_dma_reset;
		logic rx_dma_reset;
	} asdl_dma_ctrl_t;

	typedef struct packed {
		asdl_compand_t tx_mode;
		asdl_compand_t rx_mode;
		logic tx_stop_en;
		logic fifo_force_power_up;
		logic fifo_force_power_down;
	} asdl_path_ctrl_t;

	typedef struct packed {
		logic [31:0] tx_cur_dscr;
		logic [31:0] tx_next_dscr;
		logic [31:0] tx_next_buf;
		logic [31:0] rx_status;
		logic [31:0] tx_status;
	} asdl_dma_stat_t;
endpackage : asdl_pkg
